//--- can_bit_timing_resync_test.sv
// Self-checking bench comparing the bit timing block with a reference
`timescale 1ns/10ps
`default_nettype none
module can_bit_timing_resync_test;
  logic core_clk, nrst, regWrEn, regRdEn, go, busy, rxRecessive;
  logic [cbt_pkg::ADDR_W-1:0] regAddr;
  logic [15:0] regWrData, regRdData, frame, bitCycles, mReg, cfg;
  logic [4:0]  oscillatorTrim;
  logic        tqTick, bitStart, samplePoint, sampledBit, busIdle;
  int failures, samples_checked, cycles, seed, per, mDiv, st, cnt;
  int l1, l2, jump, recCnt, k, trim, nomQ;
  logic lvl, prevLvl, edg, done, mBs, mSp, mSb;  // Reference engine state
  cbt_bit_timing i_dut (.core_clk(core_clk), .nrst(nrst), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData(regRdData), .oscillatorTrim(oscillatorTrim),
    .rxRecessive(rxRecessive), .tqTick(tqTick), .bitStart(bitStart),
    .samplePoint(samplePoint), .sampledBit(sampledBit), .busIdle(busIdle));
  cbt_can_node i_node (.core_clk(core_clk), .go(go), .frame(frame),
    .bitCycles(bitCycles), .rxRecessive(rxRecessive), .busy(busy));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report
  // One strobe cycle; read data is settled by the next falling edge
  task automatic regAcc(input logic wr, input logic [3:0] a,
                        input logic [15:0] d);
    @(negedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= wr;
    regRdEn <= !wr;
    @(negedge core_clk);
    regWrEn <= 1'b0;
    regRdEn <= 1'b0;
  endtask : regAcc
  // A zero field behaves as one quantum
  task automatic load;
    l1 = (mReg[4:0] == 5'h0) ? 1 : int'(mReg[4:0]);
    l2 = (mReg[9:5] == 5'h0) ? 1 : int'(mReg[9:5]);
    done = 1'b0;
  endtask : load
  // Reference engine, one step per quantum, outputs act as registers
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mDiv = 0;
      st = 3;
      prevLvl = 1'b1;
      {mBs, mSp, mSb, done} = 4'h2;
    end else begin
      {mBs, mSp} = 2'h0;
      if (mDiv == per - 1) begin
        mDiv = 0;
        lvl = rxRecessive;
        // Only the first edge of a bit may adjust it
        edg = (lvl != prevLvl) && !done;
        jump = lvl ? 1 : 1 + mReg[11:10];
        prevLvl = lvl;
        cnt++;
        case (st)
          3: if (!lvl && edg) begin
            {st, cnt, recCnt, mBs} = {32'd1, 32'd0, 32'd0, 1'b1};
            load();
          end
          0: {st, cnt} = {32'd1, 32'd0};
          1: begin
            if (edg) {l1, done} = {l1 + jump, 1'b1};
            if (cnt >= l1) begin
              {mSp, mSb, st, cnt} = {1'b1, lvl, 32'd2, 32'd0};
              recCnt = lvl ? recCnt + 1 : 0;
            end
          end
          default: if (edg && l2 - cnt + 1 <= jump) begin
            {st, cnt, mBs} = {32'd1, 32'd0, 1'b1};
            load();
          end else begin
            if (edg) {l2, done} = {l2 - jump, 1'b1};
            if (cnt >= l2) begin
              st = (recCnt >= 11) ? 3 : 0;
              mBs = (st == 0);
              load();
            end
          end
        endcase
      end else mDiv++;
    end
  end
  // Every cycle out of reset, the five timing outputs against the reference
  always @(negedge core_clk) begin
    if (nrst) begin
      check({15'h0, tqTick}, {15'h0, mDiv == per - 1});
      check({15'h0, bitStart}, {15'h0, mBs});
      check({15'h0, samplePoint}, {15'h0, mSp});
      check({15'h0, sampledBit}, {15'h0, mSb});
      check({15'h0, busIdle}, {15'h0, st == 3});
    end
  end
  // Hang guard, well above the longest expected run
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 80000) begin
      failures++;
      final_report();
    end
  end
  initial begin
    seed = 32'ha7b7a8aa;
    {nrst, regWrEn, regRdEn, go} = 4'h0;
    {regAddr, regWrData, oscillatorTrim} = '0;
    {frame, bitCycles, per} = {16'hffff, 16'd40, 32'd40};
    for (k = 0; k < 4; k++) begin
      // Fresh reset with a new signed trim per run
      @(negedge core_clk);
      nrst <= 1'b0;
      trim = $random(seed) % 8;
      oscillatorTrim <= trim[4:0];
      per = int'(cbt_pkg::TQ_CYCLES) + trim;
      mReg = cbt_pkg::BTC_RESET;
      repeat (2) @(negedge core_clk);
      nrst <= 1'b1;
      regAcc(1'b0, cbt_pkg::BTC_ADDR, 16'h0);
      check(regRdData, cbt_pkg::BTC_RESET);
      // Run 0 has all fields zero; upper bits test the mask
      cfg = (k == 0) ? 16'hf000 : 16'($random(seed)) & 16'hfc67;
      regAcc(1'b1, 4'h3, 16'hffff);
      regAcc(1'b0, 4'h3, 16'h0);
      check(regRdData, 16'h0);
      regAcc(1'b1, cbt_pkg::BTC_ADDR, cfg);
      mReg = cfg & cbt_pkg::BTC_MASK;
      regAcc(1'b0, cbt_pkg::BTC_ADDR, 16'h0);
      check(regRdData, mReg);
      // Node bit time drifts by under one quantum from nominal
      // Own copy of the nominal length, so the reference state is untouched
      nomQ = 1 + ((mReg[4:0] == 5'h0) ? 1 : int'(mReg[4:0]))
           + ((mReg[9:5] == 5'h0) ? 1 : int'(mReg[9:5]));
      bitCycles = 16'(nomQ * per + $random(seed) % per);
      frame <= {1'b0, 15'($random(seed))};
      go <= 1'b1;
      @(negedge core_clk);
      go <= 1'b0;
      repeat (2) @(negedge core_clk);
      while (busy || !busIdle) @(negedge core_clk);
      $display("test %0d done", k);
    end
    final_report();
  end
endmodule : can_bit_timing_resync_test
`default_nettype wire

//--- cbt_bit_timing.sv
// Bit timing and resynchronisation logic of the CAN receive path
// Summary of operation
// - Bit lasts one plus both phase segments
// - Sample taken at end of first segment
// - Frame start edge clears the bit counter
// - First later edge of each bit lengthens or shortens it
// - Edge in first segment extends that segment
// - Edge in second segment shortens that segment
// - Jump one quantum, or one plus extension
// - Quantum comes from the trimmed oscillator
`timescale 1ns/10ps
`default_nettype none
module cbt_bit_timing (
  input  wire logic                        core_clk,
  input  wire logic                        nrst,
  input  wire logic                        regWrEn,
  input  wire logic                        regRdEn,
  input  wire logic [cbt_pkg::ADDR_W-1:0]  regAddr,
  input  wire logic [cbt_pkg::DATA_W-1:0]  regWrData,
  output logic      [cbt_pkg::DATA_W-1:0]  regRdData,
  input  wire logic [cbt_pkg::TRIM_W-1:0]  oscillatorTrim,
  input  wire logic                        rxRecessive,
  output logic                             tqTick,
  output logic                             bitStart,
  output logic                             samplePoint,
  output logic                             sampledBit,
  output logic                             busIdle
);
  // Control register and its read-back
  logic [cbt_pkg::DATA_W-1:0] ctrl_q, ctrl_d;    // Timing control
  logic [cbt_pkg::DATA_W-1:0] rd_q, rd_d;        // Read data holder
  // Quantum divider
  logic [cbt_pkg::DIV_W-1:0]  divCnt_q, divCnt_d; // Cycle counter
  logic [cbt_pkg::DIV_W-1:0]  tqLimit;            // Trimmed period
  // Bit segment engine
  cbt_pkg::cbt_state_t        st_q, st_d;         // Segment state
  logic [cbt_pkg::CNT_W-1:0]  cnt_q, cnt_d;       // Quanta in segment
  logic [cbt_pkg::CNT_W-1:0]  lim1_q, lim1_d;     // Live seg1 length
  logic [cbt_pkg::CNT_W-1:0]  lim2_q, lim2_d;     // Live seg2 length
  logic                       rs_q, rs_d;         // Resync used this bit
  logic                       rxPrev_q, rxPrev_d; // Level at last quantum
  logic                       samp_q, samp_d;     // Sample pulse
  logic                       bs_q, bs_d;         // Bit start pulse
  logic                       sbit_q, sbit_d;     // Sampled level
  logic [3:0]                 idle_q, idle_d;     // Recessive run
  logic [cbt_pkg::CNT_W:0]    qb_q, qb_d;         // Quanta in this bit
  // Decoded fields and edge terms
  logic [cbt_pkg::SEG_W-1:0]  p1f, p2f;           // Raw segment fields
  logic [cbt_pkg::CNT_W-1:0]  p1, p2;             // Segments, at least 1
  logic [cbt_pkg::CNT_W-1:0]  sjw;                // Jump width of edge
  logic [cbt_pkg::CNT_W-1:0]  rem;                // Seg2 quanta left
  logic                       edgeSeen, fallEdge; // Edges at this quantum

  // Field decode; a zero segment would stall the bit, so it reads as one
  always_comb begin
    p1f = ctrl_q[cbt_pkg::P1_LSB +: cbt_pkg::SEG_W];
    p2f = ctrl_q[cbt_pkg::P2_LSB +: cbt_pkg::SEG_W];
    p1  = (p1f == 5'h00) ? 6'h01 : {1'b0, p1f};
    p2  = (p2f == 5'h00) ? 6'h01 : {1'b0, p2f};
  end

  // Register port: one word at its address, others read as zero
  always_comb begin
    ctrl_d = ctrl_q;
    rd_d   = rd_q;
    if (regWrEn && regAddr == cbt_pkg::BTC_ADDR) begin
      ctrl_d = regWrData & cbt_pkg::BTC_MASK;
    end
    if (regRdEn) begin
      rd_d = (regAddr == cbt_pkg::BTC_ADDR) ? ctrl_q : 16'h0000;
    end
  end

  // trimmed quantum divider
  // Trim is signed cycles per quantum, so calibration error carries over
  always_comb begin
    tqLimit  = cbt_pkg::DIV_W'(cbt_pkg::TQ_CYCLES)
             + {{(cbt_pkg::DIV_W-cbt_pkg::TRIM_W)
                 {oscillatorTrim[cbt_pkg::TRIM_W-1]}},
                oscillatorTrim};
    tqTick   = (divCnt_q >= tqLimit - 7'h01);
    divCnt_d = tqTick ? 7'h00 : divCnt_q + 7'h01;
  end

  // Edge terms, seen once per quantum against the previous level
  always_comb begin
    edgeSeen = rxRecessive != rxPrev_q;
    fallEdge = rxPrev_q && !rxRecessive;
    sjw = fallEdge
        ? 6'h01 + {4'h0, ctrl_q[cbt_pkg::TD_LSB +: cbt_pkg::TD_W]}
        : 6'h01;
    rem = lim2_q - cnt_q;
  end

  // Segment engine; only one resync per bit, as a burst of edges
  // within a bit would otherwise walk the sample point away
  always_comb begin
    st_d     = st_q;
    cnt_d    = cnt_q;
    lim1_d   = lim1_q;
    lim2_d   = lim2_q;
    rs_d     = rs_q;
    rxPrev_d = rxPrev_q;
    samp_d   = 1'b0;
    bs_d     = 1'b0;
    sbit_d   = sbit_q;
    idle_d   = idle_q;
    qb_d     = qb_q;
    if (tqTick) begin
      rxPrev_d = rxRecessive;
      qb_d     = qb_q + 7'h01;
      unique case (st_q)
        // Waiting for the edge that opens a frame
        cbt_pkg::ST_IDLE: begin
          if (fallEdge) begin
            st_d   = cbt_pkg::ST_PH1;
            cnt_d  = 6'h00;
            lim1_d = p1;
            lim2_d = p2;
            rs_d   = 1'b0;
            bs_d   = 1'b1;
            qb_d   = 7'h01;
            idle_d = 4'h0;
          end
        end
        cbt_pkg::ST_SYNC: begin
          st_d   = cbt_pkg::ST_PH1;
          cnt_d  = 6'h00;
          lim1_d = p1;
          lim2_d = p2;
          rs_d   = 1'b0;
        end
        // First phase segment, ends in the sample point
        cbt_pkg::ST_PH1: begin
          if (edgeSeen && !rs_q) begin
            lim1_d = lim1_q + sjw;
            rs_d   = 1'b1;
          end
          if (cnt_q == lim1_d - 6'h01) begin
            st_d   = cbt_pkg::ST_PH2;
            cnt_d  = 6'h00;
            samp_d = 1'b1;
            sbit_d = rxRecessive;
            if (!rxRecessive) begin
              idle_d = 4'h0;
            end else if (idle_q != cbt_pkg::IDLE_BITS) begin
              idle_d = idle_q + 4'h1;
            end
          end else begin
            cnt_d = cnt_q + 6'h01;
          end
        end
        // Second phase segment
        cbt_pkg::ST_PH2: begin
          if (edgeSeen && !rs_q && rem <= sjw) begin
            st_d   = cbt_pkg::ST_PH1;
            cnt_d  = 6'h00;
            lim1_d = p1;
            lim2_d = p2;
            rs_d   = 1'b0;
            bs_d   = 1'b1;
            qb_d   = 7'h01;
          end else begin
            if (edgeSeen && !rs_q) begin
              lim2_d = lim2_q - sjw;
              rs_d   = 1'b1;
            end
            if (cnt_q >= lim2_d - 6'h01) begin
              cnt_d = 6'h00;
              if (idle_q == cbt_pkg::IDLE_BITS) begin
                st_d = cbt_pkg::ST_IDLE;
              end else begin
                st_d = cbt_pkg::ST_SYNC;
                bs_d = 1'b1;
                qb_d = 7'h00;
              end
            end else begin
              cnt_d = cnt_q + 6'h01;
            end
          end
        end
      endcase
    end
  end

  // State registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q   <= cbt_pkg::BTC_RESET;
      rd_q     <= 16'h0000;
      divCnt_q <= 7'h00;
      st_q     <= cbt_pkg::ST_IDLE;
      cnt_q    <= 6'h00;
      lim1_q   <= 6'h01;
      lim2_q   <= 6'h01;
      rs_q     <= 1'b0;
      rxPrev_q <= 1'b1;
      samp_q   <= 1'b0;
      bs_q     <= 1'b0;
      sbit_q   <= 1'b1;
      idle_q   <= 4'h0;
      qb_q     <= 7'h00;
    end else begin
      ctrl_q   <= ctrl_d;
      rd_q     <= rd_d;
      divCnt_q <= divCnt_d;
      st_q     <= st_d;
      cnt_q    <= cnt_d;
      lim1_q   <= lim1_d;
      lim2_q   <= lim2_d;
      rs_q     <= rs_d;
      rxPrev_q <= rxPrev_d;
      samp_q   <= samp_d;
      bs_q     <= bs_d;
      sbit_q   <= sbit_d;
      idle_q   <= idle_d;
      qb_q     <= qb_d;
    end
  end

  // Outputs from flip-flops; busIdle is decoded from the state register
  assign regRdData   = rd_q;
  assign samplePoint = samp_q;
  assign bitStart    = bs_q;
  assign sampledBit  = sbit_q;
  assign busIdle     = (st_q == cbt_pkg::ST_IDLE);

  // Checks on the timing engine
  bitLength_a: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (tqTick && st_q == cbt_pkg::ST_PH2 && st_d == cbt_pkg::ST_SYNC
      && !rs_q)
      |-> (qb_q == {1'b0, lim1_q} + {1'b0, lim2_q}))
    else $error("Unadjusted bit length wrong");
  sampleAtEnd_a: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (tqTick && st_q == cbt_pkg::ST_PH1 && !edgeSeen
      && cnt_q == lim1_q - 6'h01)
      |=> samplePoint && st_q == cbt_pkg::ST_PH2 && cnt_q == 6'h00)
    else $error("Sample point misplaced");
  hardSync_a: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (tqTick && st_q == cbt_pkg::ST_IDLE && fallEdge)
      |=> bitStart && st_q == cbt_pkg::ST_PH1 && cnt_q == 6'h00)
    else $error("Hard sync missed");
  seg1Extend_a: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (tqTick && st_q == cbt_pkg::ST_PH1 && edgeSeen && !rs_q)
      |=> lim1_q == $past(lim1_q) + $past(sjw) && rs_q)
    else $error("First segment not lengthened");
  seg2Shorten_a: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (tqTick && st_q == cbt_pkg::ST_PH2 && edgeSeen && !rs_q && rem > sjw)
      |=> lim2_q == $past(lim2_q) - $past(sjw))
    else $error("Second segment not shortened");
  jumpWidth_a: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (tqTick && st_q == cbt_pkg::ST_PH1 && edgeSeen && !rs_q && !fallEdge)
      |=> lim1_q == $past(lim1_q) + 6'h01)
    else $error("Rising edge jump not one quantum");
  quantumGap_a: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (tqTick && $stable(oscillatorTrim))
      |=> !tqTick [*2])
    else $error("Quantum ticks too close");
  syncQuiet_a: assert property (
    @(posedge core_clk) disable iff (!nrst)
    (tqTick && st_q == cbt_pkg::ST_SYNC)
      |=> st_q == cbt_pkg::ST_PH1 && lim1_q == p1 && lim2_q == p2 && !rs_q)
    else $error("Sync quantum adjusted bit");
endmodule : cbt_bit_timing
`default_nettype wire

//--- cbt_can_node.sv
// Bus node model that serialises one frame onto the received line
`timescale 1ns/10ps
`default_nettype none
module cbt_can_node (
  input  wire logic        core_clk,
  input  wire logic        go,
  input  wire logic [15:0] frame,
  input  wire logic [15:0] bitCycles,
  output logic             rxRecessive,
  output logic             busy
);
  int unsigned cyc;  // Cycles spent in the current bit
  int unsigned idx;  // Bit index, first bit sent is bit 15
  initial begin
    rxRecessive = 1'b1;
    busy = 1'b0;
  end
  // Own bit clock, so its drift against the block forces resyncs
  always @(negedge core_clk) begin
    if (go && !busy) begin
      busy <= 1'b1;
      idx <= 15;
      cyc <= 1;
      rxRecessive <= frame[15];
    end else if (busy) begin
      if (cyc < bitCycles) cyc <= cyc + 1;
      // Line released to recessive once the frame is out
      else if (idx == 0) begin
        busy <= 1'b0;
        rxRecessive <= 1'b1;
      end else begin
        idx <= idx - 1;
        cyc <= 1;
        rxRecessive <= frame[idx-1];
      end
    end
  end
endmodule : cbt_can_node
`default_nettype wire

//--- cbt_pkg.sv
// Constants, register layout and state encoding for the CAN bit timing block
package cbt_pkg;
  // Core clock period and time quantum length
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned TQ_NS         = 1000;
  localparam int unsigned TQ_CYCLES     = TQ_NS / CLK_PERIOD_NS;
  // Divider counter width, large enough for the trimmed quantum
  localparam int unsigned DIV_W         = 7;
  // Signed oscillator trim width, in core clock cycles per quantum
  localparam int unsigned TRIM_W        = 5;
  // Register port address width and the control register address
  localparam int unsigned ADDR_W        = 4;
  localparam logic [ADDR_W-1:0] BTC_ADDR = 4'ha;
  localparam int unsigned DATA_W        = 16;
  // Control register field layout
  localparam int unsigned SEG_W         = 5;
  localparam int unsigned P1_LSB        = 0;
  localparam int unsigned P2_LSB        = 5;
  localparam int unsigned TD_LSB        = 10;
  localparam int unsigned TD_W          = 2;
  // Writable bits and reset value: seg1 6, seg2 3, extension 1
  localparam logic [DATA_W-1:0] BTC_MASK  = 16'h0fff;
  localparam logic [DATA_W-1:0] BTC_RESET = 16'h0466;
  // Quantum counter width, covers a segment plus the widest jump
  localparam int unsigned CNT_W         = 6;
  // Recessive sample points that mark the bus idle again
  localparam logic [3:0] IDLE_BITS      = 4'hb;
  // Bit segment states, Gray along sync, seg1, seg2
  typedef enum logic [1:0] {
    ST_SYNC = 2'h0,
    ST_PH1  = 2'h1,
    ST_PH2  = 2'h3,
    ST_IDLE = 2'h2
  } cbt_state_t;
endpackage : cbt_pkg
